// >>> src/hrx_consts.svh
`ifndef HRX_CONSTS_SVH
`define HRX_CONSTS_SVH
// register indices; byte address is four times the index
`define HRX_IDX_CFG    10'h038
`define HRX_IDX_ICS    10'h039
`define HRX_IDX_STAT   10'h03A
`define HRX_IDX_DATA   10'h03B
// field positions
`define HRX_CFG_EN     0
`define HRX_CFG_TERM   1
`define HRX_ICS_SEL_LO 1
`define HRX_ICS_SEL_HI 2
// reset and field values
`define HRX_VBC_RST    3'h7
`define HRX_VBC_FULL   3'h7
`define HRX_VBC_NONE   3'h0
`define HRX_SEL_OFF    2'h0
`define HRX_SEL_ONE    2'h1
`define HRX_SEL_TWO    2'h2
// line patterns, oldest bit in the msb
`define HRX_FLAG       8'h7E
`define HRX_ABORT      8'h7F
`define HRX_STUFF      7'h3E
// frame check
`define HRX_CRC_INIT   16'hFFFF
`define HRX_CRC_POLY   16'h8408
`define HRX_CRC_GOOD   16'hF0B8
// counts
`define HRX_DEPTH      3'h4
`define HRX_FULL_BYTE  4'h8
`define HRX_DLY_FULL   3'h7
`endif

// >>> src/hrx_pkg.sv
package hrx_pkg;
    typedef enum logic {hrx_all_ones, hrx_flags} hrx_state_t;
    typedef struct packed {
        logic       seen;
        logic       fin;
        logic       crc_err;
        logic [2:0] vbc;
        logic [7:0] data;
    } hrx_entry_t;
endpackage

// >>> src/hrx_link_receiver.sv
// The APB interface to the registers is this design's own decision.
`include "hrx_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module hrx_link_receiver
    import hrx_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        link_bit_clk,
    input  wire logic        link_bit_data,
    output logic             link_irq,
    output logic             message_end_output
);

    logic             clk_s1_ff;
    logic             clk_s2_ff;
    logic             clk_s3_ff;
    logic             dat_s1_ff;
    logic             dat_s2_ff;
    logic             en_ff;
    logic             term_ff;
    logic [1:0]       sel_ff;
    logic             ovf_ff;
    logic             ovf_seen_ff;
    logic             dat_ok_ff;
    logic             udr_ff;
    logic             ev_ff;
    logic             oirq_ff;
    logic             irq_ff;
    logic [31:0]      prdata_ff;
    hrx_state_t       st_ff;
    logic [7:0]       hist_ff;
    logic [6:0]       dly_ff;
    logic [2:0]       dcnt_ff;
    logic [7:0]       asm_ff;
    logic [3:0]       acnt_ff;
    logic [15:0]      crc_ff;
    hrx_entry_t       mem_ff [4];
    logic [1:0]       wp_ff;
    logic [1:0]       rp_ff;
    logic [2:0]       cnt_ff;
    hrx_entry_t       last_ff;

    logic             run;
    logic             bit_evt;
    logic [7:0]       hist_n;
    logic             in_flags;
    logic             flag_det;
    logic             abt_det;
    logic             stf_det;
    logic             in_bit;
    logic             out_bit;
    logic             ob;
    logic [2:0]       vbc_n;
    logic [15:0]      crc_n;
    logic             push_v;
    hrx_entry_t       push_d;
    logic             pop;
    logic             ovf_set;
    logic [9:0]       idx;
    logic             setup;
    logic             acc;
    logic             stat_rd;
    logic             dat_rd;
    logic             cfg_wr;
    logic             ics_wr;
    logic             mapped;
    logic [7:0]       stat_v;
    logic [7:0]       rd_byte;
    logic             fill_hit;
    logic             int_lat;

    // link pins come from another domain
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            clk_s1_ff <= 1'b0;
            clk_s2_ff <= 1'b0;
            clk_s3_ff <= 1'b0;
            dat_s1_ff <= 1'b0;
            dat_s2_ff <= 1'b0;
        end
        else
        begin
            clk_s1_ff <= link_bit_clk;
            clk_s2_ff <= clk_s1_ff;
            clk_s3_ff <= clk_s2_ff;
            dat_s1_ff <= link_bit_data;
            dat_s2_ff <= dat_s1_ff;
        end
    end

    // apb decode
    assign idx     = paddr[11:2];
    assign setup   = psel & ~penable;
    assign acc     = psel & penable;
    assign stat_rd = acc & ~pwrite & (idx == `HRX_IDX_STAT);
    assign dat_rd  = acc & ~pwrite & (idx == `HRX_IDX_DATA);
    assign cfg_wr  = acc & pwrite & (idx == `HRX_IDX_CFG);
    assign ics_wr  = acc & pwrite & (idx == `HRX_IDX_ICS);
    assign mapped  = (idx == `HRX_IDX_CFG) | (idx == `HRX_IDX_ICS) |
                     (idx == `HRX_IDX_STAT) | (idx == `HRX_IDX_DATA);
    // zero wait states: read data is captured in the setup cycle
    assign pready  = 1'b1;
    assign pslverr = acc & ~mapped;
    assign prdata  = prdata_ff;

    // terminate is a one-cycle pulse, so it always reads back zero
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            en_ff   <= 1'b0;
            term_ff <= 1'b0;
            sel_ff <= `HRX_SEL_OFF;
        end
        else
        begin
            term_ff <= cfg_wr & pwdata[`HRX_CFG_TERM];
            if (cfg_wr)
                en_ff <= pwdata[`HRX_CFG_EN];
            if (ics_wr)
                sel_ff <= pwdata[`HRX_ICS_SEL_HI:`HRX_ICS_SEL_LO];
        end
    end

    // disable, terminate and overrun all hold the receiver in reset
    assign run      = en_ff & ~ovf_ff & ~term_ff;
    assign bit_evt  = run & clk_s2_ff & ~clk_s3_ff;
    assign hist_n   = {hist_ff[6:0], dat_s2_ff};
    assign in_flags = (st_ff == hrx_flags);
    assign flag_det = bit_evt & (hist_n == `HRX_FLAG);
    // eight or more ones always pass through this pattern first
    assign abt_det  = bit_evt & (hist_n == `HRX_ABORT);
    assign stf_det  = bit_evt & (hist_n[6:0] == `HRX_STUFF);
    assign in_bit   = bit_evt & in_flags & ~flag_det & ~abt_det & ~stf_det;
    // seven-bit delay keeps the head of a flag or abort out of the data
    assign out_bit  = in_bit & (dcnt_ff == `HRX_DLY_FULL);
    assign ob       = dly_ff[6];
    assign vbc_n    = 3'(acnt_ff - 4'h1);
    assign crc_n    = {1'b0, crc_ff[15:1]} ^ ((crc_ff[0] ^ ob) ? `HRX_CRC_POLY : 16'h0000);

    always_comb
    begin
        push_v = 1'b0;
        push_d = '0;
        if (flag_det && !in_flags)
        begin
            // dummy byte; its count and crc carry no meaning
            push_v      = 1'b1;
            push_d.seen = 1'b1;
            push_d.fin  = 1'b1;
        end
        else if (flag_det && (acnt_ff != 4'h0))
        begin
            push_v         = 1'b1;
            push_d.seen    = 1'b1;
            push_d.fin     = 1'b1;
            push_d.crc_err = (crc_ff != `HRX_CRC_GOOD);
            push_d.vbc     = vbc_n;
            push_d.data    = asm_ff;
        end
        else if (abt_det && in_flags)
        begin
            push_v      = 1'b1;
            push_d.fin  = 1'b1;
            push_d.vbc  = (acnt_ff == 4'h0) ? `HRX_VBC_NONE : vbc_n;
            push_d.data = asm_ff;
        end
        else if (out_bit && (acnt_ff == `HRX_FULL_BYTE))
        begin
            // a full byte waits for the next bit so the last one can carry end
            push_v      = 1'b1;
            push_d.seen = 1'b1;
            push_d.vbc  = `HRX_VBC_FULL;
            push_d.data = asm_ff;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_ff   <= hrx_all_ones;
            hist_ff <= 8'h00;
        end
        else if (!run)
        begin
            st_ff   <= hrx_all_ones;
            hist_ff <= 8'h00;
        end
        else if (bit_evt)
        begin
            hist_ff <= hist_n;
            case (1'b1)
                flag_det: st_ff <= hrx_flags;
                abt_det: st_ff <= hrx_all_ones;
                default: st_ff <= st_ff;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            dly_ff  <= 7'h00;
            dcnt_ff <= 3'h0;
        end
        else if (!run || flag_det || abt_det)
            dcnt_ff <= 3'h0;
        else if (in_bit)
        begin
            dly_ff <= {dly_ff[5:0], dat_s2_ff};
            if (dcnt_ff != `HRX_DLY_FULL)
                dcnt_ff <= dcnt_ff + 3'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            asm_ff  <= 8'h00;
            acnt_ff <= 4'h0;
            crc_ff  <= `HRX_CRC_INIT;
        end
        else if (!run || flag_det || abt_det)
        begin
            acnt_ff <= 4'h0;
            crc_ff  <= `HRX_CRC_INIT;
        end
        else if (out_bit)
        begin
            asm_ff  <= {ob, asm_ff[7:1]};
            acnt_ff <= (acnt_ff == `HRX_FULL_BYTE) ? 4'h1 : acnt_ff + 4'h1;
            crc_ff  <= crc_n;
        end
    end

    // fifo
    // only a byte that the setup cycle handed out is popped
    assign pop     = dat_rd & dat_ok_ff & (cnt_ff != 3'h0);
    assign ovf_set = push_v & (cnt_ff == `HRX_DEPTH) & ~pop;

    always_ff @(posedge pclk)
    begin
        if (push_v && (cnt_ff != `HRX_DEPTH || pop))
            mem_ff[wp_ff] <= push_d;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wp_ff  <= 2'h0;
            rp_ff  <= 2'h0;
            cnt_ff <= 3'h0;
        end
        else if (!run || ovf_set)
        begin
            // held empty while overrun stands
            wp_ff  <= 2'h0;
            rp_ff  <= 2'h0;
            cnt_ff <= 3'h0;
        end
        else
        begin
            if (push_v)
                wp_ff <= wp_ff + 2'h1;
            if (pop)
                rp_ff <= rp_ff + 2'h1;
            cnt_ff <= cnt_ff + {2'h0, push_v} - {2'h0, pop};
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            last_ff <= '{seen: 1'b0, fin: 1'b0, crc_err: 1'b0, vbc: `HRX_VBC_RST, data: 8'h00};
        else if (!run)
        begin
            last_ff.seen <= 1'b0;
            last_ff.fin  <= 1'b0;
        end
        else if (pop)
            last_ff <= mem_ff[rp_ff];
    end

    // status flags; hardware set wins over the software clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ovf_ff  <= 1'b0;
            udr_ff  <= 1'b0;
            ev_ff   <= 1'b0;
            oirq_ff <= 1'b0;
            irq_ff  <= 1'b0;
        end
        else
        begin
            ovf_ff  <= ovf_set | (ovf_ff & ~(stat_rd & ovf_seen_ff));
            udr_ff  <= (dat_rd & ~dat_ok_ff) | (udr_ff & ~stat_rd);
            ev_ff   <= (push_v & push_d.fin) |
                       (ev_ff & run & ~(pop & (cnt_ff == 3'h1) & ~push_v));
            oirq_ff <= ovf_set | (oirq_ff & ~(stat_rd & ovf_seen_ff) & en_ff & ~term_ff);
            irq_ff  <= (sel_ff != `HRX_SEL_OFF) & int_lat;
        end
    end

    always_comb
    begin
        case (sel_ff)
            `HRX_SEL_OFF: fill_hit = 1'b0;
            `HRX_SEL_ONE: fill_hit = (cnt_ff != 3'h0);
            `HRX_SEL_TWO: fill_hit = (cnt_ff >= 3'h2);
            default:      fill_hit = (cnt_ff >= 3'h3);
        endcase
    end

    assign int_lat            = fill_hit | ev_ff | oirq_ff;
    assign link_irq           = irq_ff;
    // overrun reports end of message at once
    assign message_end_output = last_ff.fin | ovf_ff;
    assign stat_v = {cnt_ff == 3'h0, ovf_ff, last_ff.seen, message_end_output,
                     last_ff.crc_err, last_ff.vbc};

    always_comb
    begin
        case (idx)
            `HRX_IDX_CFG:  rd_byte = {7'h00, en_ff};
            `HRX_IDX_ICS:  rd_byte = {5'h00, sel_ff, (sel_ff != `HRX_SEL_OFF) ? irq_ff : int_lat};
            `HRX_IDX_STAT: rd_byte = udr_ff ? 8'h00 : stat_v;
            `HRX_IDX_DATA: rd_byte = (cnt_ff != 3'h0) ? mem_ff[rp_ff].data : 8'h00;
            default:       rd_byte = 8'h00;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_ff   <= 32'h0000_0000;
            dat_ok_ff   <= 1'b0;
            ovf_seen_ff <= 1'b0;
        end
        else if (setup && !pwrite)
        begin
            // the access edge acts only on what this cycle reported, so a byte
            // or an overrun landing in between is not lost
            prdata_ff   <= {24'h00_0000, rd_byte};
            dat_ok_ff   <= (cnt_ff != 3'h0);
            ovf_seen_ff <= ovf_ff;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_first_flag;
        flag_det && !in_flags;
    endsequence
    sequence s_udr_read;
        dat_rd && !dat_ok_ff;
    endsequence

    property p_empty_low;
        push_v && run && !ovf_set |=> cnt_ff != 3'h0;
    endproperty
    a_empty_low: assert property (p_empty_low) else $error("fifo empty after push");

    property p_ovf_set;
        ovf_set |=> ovf_ff && (cnt_ff == 3'h0) && message_end_output;
    endproperty
    a_ovf_set: assert property (p_ovf_set) else $error("overrun not flagged");

    property p_ovf_hold;
        ovf_ff && !stat_rd |=> ovf_ff && (cnt_ff == 3'h0) && !last_ff.seen;
    endproperty
    a_ovf_hold: assert property (p_ovf_hold) else $error("overrun released early");

    property p_first_flag;
        s_first_flag |-> push_v && push_d.fin && push_d.seen ##1 st_ff == hrx_flags;
    endproperty
    a_first_flag: assert property (p_first_flag) else $error("first flag mishandled");

    property p_abort;
        abt_det && in_flags |-> push_v && !push_d.seen ##1 st_ff == hrx_all_ones;
    endproperty
    a_abort: assert property (p_abort) else $error("abort not pushed");

    property p_underrun;
        s_udr_read |=> $stable(rp_ff) && udr_ff;
    endproperty
    a_underrun: assert property (p_underrun) else $error("underrun moved pointer");

    property p_udr_zero;
        udr_ff && setup && !pwrite && (idx == `HRX_IDX_STAT) |=> prdata_ff == 32'h0000_0000;
    endproperty
    a_udr_zero: assert property (p_udr_zero) else $error("status not zero after underrun");

    property p_irq_off;
        sel_ff == `HRX_SEL_OFF |=> !link_irq;
    endproperty
    a_irq_off: assert property (p_irq_off) else $error("interrupt while disabled");

    property p_pop_status;
        pop |=> last_ff == $past(mem_ff[rp_ff]);
    endproperty
    a_pop_status: assert property (p_pop_status) else $error("status not from read byte");

endmodule

`default_nettype wire

// >>> tb/hrx_bit_source.sv
`timescale 1ns/1ps
`default_nettype none

module hrx_bit_source
(
    input  wire logic pclk,
    output logic      link_bit_clk,
    output logic      link_bit_data
);
    // the bench raises this to model a slow line
    int half_cycles = 4;

    initial
    begin
        link_bit_clk = 1'b0;
        link_bit_data = 1'b1;
    end

    // data settles a full low phase before the rise, the receiver's sync needs both phases long
    task automatic put_bit(input logic b);
        @(posedge pclk);
        link_bit_data <= b;
        repeat (half_cycles) @(posedge pclk);
        link_bit_clk <= 1'b1;
        repeat (half_cycles) @(posedge pclk);
        link_bit_clk <= 1'b0;
    endtask

    // bits[0] goes first; stuffing only for frame contents, never for flags or aborts
    task automatic send(input logic [63:0] bits, input int n, input logic stuff);
        int ones;
        ones = 0;
        for (int i = 0; i < n; i++)
        begin
            put_bit(bits[i]);
            ones = bits[i] ? ones + 1 : 0;
            if (stuff && ones == 5)
            begin
                put_bit(1'b0);
                ones = 0;
            end
        end
        // clock stands low between bursts, data no longer holds its last value
        @(posedge pclk);
        link_bit_data <= ~link_bit_data;
        repeat (4) @(posedge pclk);
    endtask
endmodule

`default_nettype wire

// >>> tb/tb.sv
`include "hrx_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module tb;
    localparam logic [9:0] CFG  = `HRX_IDX_CFG;
    localparam logic [9:0] ICS  = `HRX_IDX_ICS;
    localparam logic [9:0] STAT = `HRX_IDX_STAT;
    localparam logic [9:0] DATA = `HRX_IDX_DATA;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        link_bit_clk;
    logic        link_bit_data;
    logic        link_irq;
    logic        message_end_output;
    logic [31:0] rd;
    logic        err;
    logic [15:0] fcs;
    int          failures;
    int          samples_checked;

    hrx_link_receiver dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .link_bit_clk(link_bit_clk), .link_bit_data(link_bit_data), .link_irq(link_irq),
        .message_end_output(message_end_output));
    hrx_bit_source src (.pclk(pclk), .link_bit_clk(link_bit_clk), .link_bit_data(link_bit_data));

    initial
    begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    task automatic apb(input logic w, input logic [9:0] idx, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    // reads until the empty flag shows; leaves the last status in rd
    task automatic drain();
        for (int i = 0; i < 6; i++)
        begin
            apb(1'b0, STAT, 32'h0000_0000);
            if (rd[7] !== 1'b0)
                break;
            apb(1'b0, DATA, 32'h0000_0000);
        end
    endtask

    function automatic logic [15:0] fcs8(input logic [7:0] d);
        logic [15:0] c;
        c = 16'hFFFF;
        for (int i = 0; i < 8; i++)
            c = (c >> 1) ^ ((c[0] ^ d[i]) ? 16'h8408 : 16'h0000);
        return ~c;
    endfunction

    task automatic final_report();
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial
    begin
        repeat (60000) @(posedge pclk);
        failures++;
        final_report();
    end

    initial
    begin
        failures = 0;
        samples_checked = 0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b1, STAT, 32'h0000_00FF);
        apb(1'b0, STAT, 32'h0000_0000);
        chk("status", 32'h0000_0087, rd);
        apb(1'b0, 10'h010, 32'h0000_0000);
        chk("pslverr", 32'h0000_0001, {31'h0, err});
        chk("unmapped", 32'h0000_0000, rd);
        $display("test reset done");
        apb(1'b1, ICS, 32'h0000_0002);
        apb(1'b1, CFG, 32'h0000_0001);
        src.send(64'h7E, 8, 1'b0);
        chk("irq", 32'h0000_0001, {31'h0, link_irq});
        apb(1'b0, DATA, 32'h0000_0000);
        chk("dummy", 32'h0000_0000, rd);
        apb(1'b0, STAT, 32'h0000_0000);
        chk("status", 32'h0000_00B0, rd & 32'h0000_00F0);
        chk("irq", 32'h0000_0000, {31'h0, link_irq});
        $display("test first flag done");
        for (int k = 0; k < 2; k++)
        begin
            fcs = fcs8(8'h35) ^ k[15:0];
            src.send({40'h0, fcs, 8'h35}, 24, 1'b1);
            src.send(64'h7E, 8, 1'b0);
            apb(1'b0, DATA, 32'h0000_0000);
            chk("data", 32'h0000_0035, rd);
            drain();
            chk("status", 32'h0000_0037 | (k << 3), rd & 32'h0000_003F);
        end
        $display("test frames done");
        src.send(64'h1FED, 13, 1'b0);
        chk("irq", 32'h0000_0001, {31'h0, link_irq});
        apb(1'b0, DATA, 32'h0000_0000);
        chk("abort data", 32'h0000_00D0, rd & 32'h0000_00F0);
        apb(1'b0, STAT, 32'h0000_0000);
        chk("status", 32'h0000_0010, rd & 32'h0000_0030);
        drain();
        apb(1'b0, DATA, 32'h0000_0000);
        chk("underrun data", 32'h0000_0000, rd);
        apb(1'b0, STAT, 32'h0000_0000);
        chk("status", 32'h0000_0000, rd);
        apb(1'b0, STAT, 32'h0000_0000);
        chk("status", 32'h0000_0080, rd & 32'h0000_0080);
        $display("test abort and underrun done");
        src.send(64'h7E, 8, 1'b0);
        drain();
        // reads are held back on purpose here, breaking the reader's deadline
        src.half_cycles = 6;
        src.send(64'h0, 40, 1'b0);
        apb(1'b0, STAT, 32'h0000_0000);
        chk("status", 32'h0000_0000, rd & 32'h0000_00C0);
        src.send(64'h0, 8, 1'b0);
        chk("eom pin", 32'h0000_0001, {31'h0, message_end_output});
        chk("irq", 32'h0000_0001, {31'h0, link_irq});
        apb(1'b0, STAT, 32'h0000_0000);
        chk("status", 32'h0000_0050, rd & 32'h0000_0070);
        apb(1'b0, STAT, 32'h0000_0000);
        chk("status", 32'h0000_0080, rd & 32'h0000_00C0);
        chk("irq", 32'h0000_0000, {31'h0, link_irq});
        src.half_cycles = 4;
        $display("test overrun done");
        for (int s = 0; s < 4; s++)
        begin
            apb(1'b1, CFG, 32'h0000_0000);
            apb(1'b1, ICS, s << 1);
            apb(1'b1, CFG, 32'h0000_0001);
            src.send(64'h7E, 8, 1'b0);
            drain();
            chk("irq", 32'h0000_0000, {31'h0, link_irq});
            for (int k = 1; k <= 3; k++)
            begin
                src.send(64'h0, (k == 1) ? 16 : 8, 1'b0);
                chk("irq", {31'h0, (s != 0 && k >= s)}, {31'h0, link_irq});
            end
            apb(1'b1, CFG, (s % 2 == 1) ? 32'h0000_0003 : 32'h0000_0000);
            apb(1'b0, STAT, 32'h0000_0000);
            chk("status", 32'h0000_0080, rd & 32'h0000_0080);
            chk("irq", 32'h0000_0000, {31'h0, link_irq});
        end
        $display("test fill select done");
        final_report();
    end
endmodule

`default_nettype wire
